// File: src/prot_blocking.v
// Protection frame and per-module blocking logic with settings port
//
// The implementer's own choices: the plain strobed port and the address map.
`include "prot_block_regs.vh"

module prot_blocking (
  input wire i_clk,
  input wire i_nrst,
  input wire [`ADDR_W-1:0] i_addr,
  input wire [`DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_din,
  input wire i_rev_interlock,
  input wire i_meas_ok,
  input wire i_param_change,
  input wire i_freq_in_range,
  input wire [`NUM_MOD-1:0] i_mod_alarm,
  input wire [`NUM_MOD-1:0] i_mod_trip,
  output reg [`DATA_W-1:0] o_rdata,
  output reg o_prot_active,
  output reg [`NUM_MOD-1:0] o_mod_active,
  output reg [`NUM_MOD-1:0] o_mod_blocked,
  output reg [`NUM_MOD-1:0] o_trip_cmd,
  output reg o_gen_alarm,
  output reg o_gen_trip
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Assignment list lookup
  // Selector zero means no assignment and never blocks
  function sel_sig;
    input [31:0] pool;
    input [`SEL_W-1:0] idx;
    begin
      if (idx == `SEL_NONE) begin
        sel_sig = 1'b0;
      end else begin
        sel_sig = pool[idx];
      end
    end
  endfunction

  function is_mod_addr;
    input [`ADDR_W-1:0] addr;
    begin
      is_mod_addr = (addr[`MOD_PAGE_MSB:`MOD_PAGE_LSB] == `MOD_PAGE);
    end
  endfunction

  function [`MOD_IDX_W-1:0] mod_idx;
    input [`ADDR_W-1:0] addr;
    begin
      mod_idx = addr[`MOD_IDX_MSB:`MOD_IDX_LSB];
    end
  endfunction

  function [`MOD_OFS_W-1:0] mod_ofs;
    input [`ADDR_W-1:0] addr;
    begin
      mod_ofs = addr[`MOD_OFS_MSB:`MOD_OFS_LSB];
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins are asynchronous to the relay clock
  reg [7:0] din_meta;
  reg [7:0] din_s;
  reg rev_meta;
  reg rev_s;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_meta <= `DIN_RST;
      din_s <= `DIN_RST;
      rev_meta <= 1'b0;
      rev_s <= 1'b0;
    end else begin
      din_meta <= i_din;
      din_s <= din_meta;
      rev_meta <= i_rev_interlock;
      rev_s <= rev_meta;
    end
  end

  // ****************************************************************
  // Settings registers
  // ****************************************************************
  reg [`GCTRL_W-1:0] gctrl;
  reg [`ASG_W-1:0] gassign;
  reg [`MCTRL_W-1:0] mctrl [0:`NUM_MOD-1];
  reg [`ASG_W-1:0] massign [0:`NUM_MOD-1];
  wire [`MOD_IDX_W-1:0] wr_mod;
  integer k;

  assign wr_mod = mod_idx(i_addr);

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gctrl <= `GCTRL_RST;
      gassign <= `ASG_RST;
      for (k = 0; k < `NUM_MOD; k = k + 1) begin
        mctrl[k] <= `MCTRL_RST;
        massign[k] <= `ASG_RST;
      end
    end else if (i_wr) begin
      if (i_addr == `REG_GCTRL) begin
        gctrl <= i_wdata[`GCTRL_W-1:0];
      end else if (i_addr == `REG_GASSIGN) begin
        gassign <= i_wdata[`ASG_W-1:0];
      end else if (is_mod_addr(i_addr)) begin
        if (mod_ofs(i_addr) == `MOD_CTRL) begin
          mctrl[wr_mod] <= i_wdata[`MCTRL_W-1:0];
        end else if (mod_ofs(i_addr) == `MOD_ASSIGN) begin
          massign[wr_mod] <= i_wdata[`ASG_W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // Signal pool
  // ****************************************************************
  // Internal states come from registers, so no loop through selection
  reg [`NUM_MOD-1:0] mod_trip;
  wire [31:0] pool;

  assign pool = {`POOL_PAD, o_mod_active, mod_trip, din_s, `POOL_NONE};

  // ****************************************************************
  // Protection frame
  // ****************************************************************
  wire glob_a;
  wire glob_b;
  wire glob_trip_in;
  wire frame_blocked;
  wire glob_trip_blk;
  wire next_prot_active;

  assign glob_a = sel_sig(pool, gassign[`ASG_A_LSB +: `SEL_W]);
  assign glob_b = sel_sig(pool, gassign[`ASG_B_LSB +: `SEL_W]);
  assign glob_trip_in = sel_sig(pool, gassign[`ASG_T_LSB +: `SEL_W]);
  assign frame_blocked = gctrl[`GC_EXT_PERMIT] & (glob_a | glob_b);
  assign next_prot_active = i_meas_ok & ~i_param_change & gctrl[`GC_ENABLE] & ~frame_blocked;
  assign glob_trip_blk = gctrl[`GC_TRIP_PERM] | (gctrl[`GC_TRIP_PERMIT] & glob_trip_in);

  // ****************************************************************
  // Module gates
  // ****************************************************************
  wire [`NUM_MOD-1:0] next_active;
  wire [`NUM_MOD-1:0] next_blocked;
  wire [`NUM_MOD-1:0] next_trip_cmd;
  wire [`NUM_MOD-1:0] next_alarm;
  wire [`NUM_MOD-1:0] next_trip;
  wire [`NUM_MOD-1:0] next_trip_blocked;
  wire [`NUM_MOD-1:0] next_freq_blocked;
  wire [`NUM_MOD-1:0] next_rev_blocked;
  wire [`NUM_MOD-1:0] next_a_state;
  wire [`NUM_MOD-1:0] next_b_state;
  wire [`NUM_MOD-1:0] next_t_state;

  genvar g;
  generate
    for (g = 0; g < `NUM_MOD; g = g + 1) begin : gate
      assign next_a_state[g] = sel_sig(pool, massign[g][`ASG_A_LSB +: `SEL_W]);
      assign next_b_state[g] = sel_sig(pool, massign[g][`ASG_B_LSB +: `SEL_W]);
      assign next_t_state[g] = sel_sig(pool, massign[g][`ASG_T_LSB +: `SEL_W]);
      prot_module_gate u_gate (
        .i_frame_active(next_prot_active),
        .i_wide_freq(gctrl[`GC_WIDE_FREQ]),
        .i_freq_in_range(i_freq_in_range),
        .i_ctrl(mctrl[g]),
        .i_blk_a(next_a_state[g]),
        .i_blk_b(next_b_state[g]),
        .i_trip_blk(next_t_state[g]),
        .i_rev(rev_s),
        .i_glob_trip_blk(glob_trip_blk),
        .i_alarm(i_mod_alarm[g]),
        .i_trip(i_mod_trip[g]),
        .o_active(next_active[g]),
        .o_blocked(next_blocked[g]),
        .o_trip_cmd(next_trip_cmd[g]),
        .o_alarm(next_alarm[g]),
        .o_trip(next_trip[g]),
        .o_trip_blocked(next_trip_blocked[g]),
        .o_freq_blocked(next_freq_blocked[g]),
        .o_rev_blocked(next_rev_blocked[g])
      );
    end
  endgenerate

  // ****************************************************************
  // State registers
  // ****************************************************************
  reg frame_blocked_q;
  reg glob_trip_blk_q;
  reg glob_a_q;
  reg glob_b_q;
  reg [`NUM_MOD-1:0] trip_blocked;
  reg [`NUM_MOD-1:0] freq_blocked;
  reg [`NUM_MOD-1:0] rev_blocked;
  reg [`NUM_MOD-1:0] a_state;
  reg [`NUM_MOD-1:0] b_state;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prot_active <= 1'b0;
      o_mod_active <= `MOD_RST;
      o_mod_blocked <= `MOD_RST;
      o_trip_cmd <= `MOD_RST;
      o_gen_alarm <= 1'b0;
      o_gen_trip <= 1'b0;
      mod_trip <= `MOD_RST;
      frame_blocked_q <= 1'b0;
      glob_trip_blk_q <= 1'b0;
      glob_a_q <= 1'b0;
      glob_b_q <= 1'b0;
      trip_blocked <= `MOD_RST;
      freq_blocked <= `MOD_RST;
      rev_blocked <= `MOD_RST;
      a_state <= `MOD_RST;
      b_state <= `MOD_RST;
    end else begin
      o_prot_active <= next_prot_active;
      o_mod_active <= next_active;
      o_mod_blocked <= next_blocked;
      o_trip_cmd <= next_trip_cmd;
      // Alarm and trip decisions ignore the trip command blocks
      o_gen_alarm <= |next_alarm;
      o_gen_trip <= |next_trip;
      mod_trip <= next_trip;
      frame_blocked_q <= frame_blocked;
      glob_trip_blk_q <= glob_trip_blk;
      glob_a_q <= glob_a;
      glob_b_q <= glob_b;
      trip_blocked <= next_trip_blocked;
      freq_blocked <= next_freq_blocked;
      rev_blocked <= next_rev_blocked;
      a_state <= next_a_state;
      b_state <= next_b_state;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  reg [`DATA_W-1:0] next_rdata;
  wire [`MOD_IDX_W-1:0] rd_mod;
  wire [`MOD_OFS_W-1:0] rd_ofs;
  wire [`GSTAT_W-1:0] gstat;
  wire [`MSTAT_W-1:0] mstat;

  assign rd_mod = mod_idx(i_addr);
  assign rd_ofs = mod_ofs(i_addr);
  // Built from registered copies, so a read never sees a half-settled gate
  assign gstat = {glob_b_q, glob_a_q, glob_trip_blk_q, frame_blocked_q, o_prot_active};
  assign mstat = {freq_blocked[rd_mod], rev_blocked[rd_mod], trip_blocked[rd_mod],
    b_state[rd_mod], a_state[rd_mod], o_trip_cmd[rd_mod], o_mod_blocked[rd_mod],
    o_mod_active[rd_mod]};

  always @* begin
    next_rdata = `ZERO32;
    if (i_addr == `REG_GCTRL) begin
      next_rdata[`GCTRL_W-1:0] = gctrl;
    end else if (i_addr == `REG_GASSIGN) begin
      next_rdata[`ASG_W-1:0] = gassign;
    end else if (i_addr == `REG_GSTAT) begin
      next_rdata[`GSTAT_W-1:0] = gstat;
    end else if (is_mod_addr(i_addr)) begin
      case (rd_ofs)
        `MOD_CTRL: begin
          next_rdata[`MCTRL_W-1:0] = mctrl[rd_mod];
        end
        `MOD_ASSIGN: begin
          next_rdata[`ASG_W-1:0] = massign[rd_mod];
        end
        `MOD_STAT: begin
          next_rdata[`MSTAT_W-1:0] = mstat;
        end
        default: begin
          next_rdata = `ZERO32;
        end
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `ZERO32;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= `ZERO32;
    end
  end

endmodule // prot_blocking

// File: src/prot_block_regs.vh
// Constants for the protection blocking logic
// ****************************************************************
// ****************************************************************
`ifndef PROT_BLOCK_REGS_VH
`define PROT_BLOCK_REGS_VH

// ****************************************************************
// Sizes
// ****************************************************************
`define ADDR_W 8
`define DATA_W 32
`define NUM_MOD 8
`define SEL_W 5
`define MCTRL_W 8
`define ASG_W 24
`define GSTAT_W 5
`define MSTAT_W 8
`define MOD_IDX_W 3
`define MOD_OFS_W 2

// ****************************************************************
// Register word addresses
// ****************************************************************
`define REG_GCTRL 8'h00
`define REG_GASSIGN 8'h01
`define REG_GSTAT 8'h02
`define MOD_PAGE 3'h1
`define MOD_CTRL 2'h0
`define MOD_ASSIGN 2'h1
`define MOD_STAT 2'h2
`define MOD_PAGE_MSB 7
`define MOD_PAGE_LSB 5
`define MOD_IDX_MSB 4
`define MOD_IDX_LSB 2
`define MOD_OFS_MSB 1
`define MOD_OFS_LSB 0

// ****************************************************************
// Global control bits
// ****************************************************************
`define GC_ENABLE 0
`define GC_EXT_PERMIT 1
`define GC_TRIP_PERM 2
`define GC_TRIP_PERMIT 3
`define GC_WIDE_FREQ 4
`define GCTRL_W 5
`define GCTRL_RST 5'h01

// ****************************************************************
// Module control bits
// ****************************************************************
`define MC_ENABLE 0
`define MC_EXT_PERMIT 1
`define MC_TRIP_PERM 2
`define MC_TRIP_PERMIT 3
`define MC_USES_RMS 4
`define MC_REV_PERMIT 5
`define MC_KIND_LSB 6
`define MC_KIND_W 2
`define MCTRL_RST 8'h00
`define KIND_PHASE 2'h1
`define KIND_GROUND 2'h2

// ****************************************************************
// Assignment fields and signal pool
// ****************************************************************
`define ASG_A_LSB 0
`define ASG_B_LSB 8
`define ASG_T_LSB 16
`define ASG_RST 24'h000000
`define SEL_NONE 5'h00
`define POOL_DIN_LSB 1
`define POOL_TRIP_LSB 9
`define POOL_ACT_LSB 17
`define ZERO32 32'h00000000
`define POOL_PAD 7'h00
`define POOL_NONE 1'b0
`define MOD_RST 8'h00
`define DIN_RST 8'h00

`endif

// File: src/prot_module_gate.v
// Blocking and trip command gating for one protection module
`include "prot_block_regs.vh"

module prot_module_gate (
  input wire i_frame_active,
  input wire i_wide_freq,
  input wire i_freq_in_range,
  input wire [`MCTRL_W-1:0] i_ctrl,
  input wire i_blk_a,
  input wire i_blk_b,
  input wire i_trip_blk,
  input wire i_rev,
  input wire i_glob_trip_blk,
  input wire i_alarm,
  input wire i_trip,
  output wire o_active,
  output wire o_blocked,
  output wire o_trip_cmd,
  output wire o_alarm,
  output wire o_trip,
  output wire o_trip_blocked,
  output wire o_freq_blocked,
  output wire o_rev_blocked
);
  wire [`MC_KIND_W-1:0] kind;
  wire rev_kind;

  assign kind = i_ctrl[`MC_KIND_LSB +: `MC_KIND_W];
  assign rev_kind = (kind == `KIND_PHASE) || (kind == `KIND_GROUND);
  // Frequency range block
  // RMS based elements stay usable off nominal
  assign o_freq_blocked = i_wide_freq & ~i_freq_in_range & ~i_ctrl[`MC_USES_RMS];
  assign o_rev_blocked = i_ctrl[`MC_REV_PERMIT] & rev_kind & i_rev;
  assign o_blocked = (i_ctrl[`MC_EXT_PERMIT] & (i_blk_a | i_blk_b)) | o_rev_blocked;
  assign o_active = i_frame_active & i_ctrl[`MC_ENABLE] & ~o_freq_blocked & ~o_blocked;
  assign o_alarm = o_active & i_alarm;
  assign o_trip = o_active & i_trip;
  assign o_trip_blocked = i_ctrl[`MC_TRIP_PERM] | (i_ctrl[`MC_TRIP_PERMIT] & i_trip_blk)
    | i_glob_trip_blk;
  assign o_trip_cmd = o_trip & ~o_trip_blocked;
endmodule // prot_module_gate

// File: bench/prot_blocking_checker.sv
// Port-level assertions for the protection blocking logic
`include "prot_block_regs.vh"

module prot_blocking_checker (
  input wire i_clk,
  input wire i_nrst,
  input wire i_rd,
  input wire i_meas_ok,
  input wire i_param_change,
  input wire [`NUM_MOD-1:0] i_mod_alarm,
  input wire [`NUM_MOD-1:0] i_mod_trip,
  input wire [`DATA_W-1:0] o_rdata,
  input wire o_prot_active,
  input wire [`NUM_MOD-1:0] o_mod_active,
  input wire [`NUM_MOD-1:0] o_mod_blocked,
  input wire [`NUM_MOD-1:0] o_trip_cmd,
  input wire o_gen_alarm,
  input wire o_gen_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ****************************************************************
  // Frame and module gating
  // ****************************************************************
  property p_meas_drop;
    (!i_meas_ok || i_param_change) |=> !o_prot_active;
  endproperty
  a_meas_drop: assert property (p_meas_drop) else $error("frame active without valid state");
  property p_mod_in_frame;
    !o_prot_active |-> o_mod_active == 8'h00;
  endproperty
  a_mod_in_frame: assert property (p_mod_in_frame) else $error("module active in idle frame");
  property p_active_unblocked;
    (o_mod_active & o_mod_blocked) == 8'h00;
  endproperty
  a_active_unblocked: assert property (p_active_unblocked) else $error("blocked module active");
  // ****************************************************************
  // Trip command and collective signals
  // ****************************************************************
  property p_trip_needs_active;
    (o_trip_cmd & ~(o_mod_active & $past(i_mod_trip))) == 8'h00;
  endproperty
  a_trip_needs_active: assert property (p_trip_needs_active) else $error("stray trip command");
  property p_trip_in_frame;
    (o_trip_cmd != 8'h00) |-> o_prot_active;
  endproperty
  a_trip_in_frame: assert property (p_trip_in_frame) else $error("trip with frame off");
  property p_gen_trip;
    o_gen_trip == |($past(i_mod_trip) & o_mod_active);
  endproperty
  a_gen_trip: assert property (p_gen_trip) else $error("general trip mismatch");
  property p_gen_alarm;
    o_gen_alarm == |($past(i_mod_alarm) & o_mod_active);
  endproperty
  a_gen_alarm: assert property (p_gen_alarm) else $error("general alarm mismatch");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule // prot_blocking_checker

bind prot_blocking prot_blocking_checker i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd),
  .i_meas_ok(i_meas_ok), .i_param_change(i_param_change), .i_mod_alarm(i_mod_alarm),
  .i_mod_trip(i_mod_trip), .o_rdata(o_rdata), .o_prot_active(o_prot_active),
  .o_mod_active(o_mod_active), .o_mod_blocked(o_mod_blocked), .o_trip_cmd(o_trip_cmd),
  .o_gen_alarm(o_gen_alarm), .o_gen_trip(o_gen_trip));

// File: bench/tb_prot_blocking.sv
// Self-checking testbench for the protection blocking logic
`include "prot_block_regs.vh"

module tb_prot_blocking;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] w; logic [31:0] e;} note_t;
  logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_rev_interlock = 0, chk = 0, pend = 0;
  logic i_meas_ok = 1, i_param_change = 0, i_freq_in_range = 1, o_prot_active, o_gen_alarm;
  logic o_gen_trip;
  logic [7:0] i_addr = 8'h00, i_din = 8'h00, i_mod_alarm = 8'h00, i_mod_trip = 8'h00;
  logic [7:0] o_mod_active, o_mod_blocked, o_trip_cmd;
  logic [31:0] i_wdata = 32'h00000000, o_rdata, seed = 32'hfb2d3c72, seen;
  int n_mismatch = 0, samples_checked = 0;
  note_t q[$];
  note_t n;
  string nm[6] = '{"rdata", "prot_active", "mod_active", "trip_cmd", "mod_blocked", "general"};

  always #25 i_clk = ~i_clk;

  prot_blocking i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_din(i_din), .i_rev_interlock(i_rev_interlock),
    .i_meas_ok(i_meas_ok), .i_param_change(i_param_change), .i_freq_in_range(i_freq_in_range),
    .i_mod_alarm(i_mod_alarm), .i_mod_trip(i_mod_trip), .o_rdata(o_rdata),
    .o_prot_active(o_prot_active), .o_mod_active(o_mod_active), .o_mod_blocked(o_mod_blocked),
    .o_trip_cmd(o_trip_cmd), .o_gen_alarm(o_gen_alarm), .o_gen_trip(o_gen_trip));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // ****************************************************************
  // Bus cycle, output probe and scoreboard
  // ****************************************************************
  // One task for write, read and probe; w 0 with r 1 is a read
  task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] w, input logic [31:0] e);
    @(posedge i_clk);
    i_wr <= wr;
    i_rd <= rd;
    chk <= (w != 3'h0);
    i_addr <= a;
    i_wdata <= d;
    if (rd || w != 3'h0) q.push_back('{w, e});
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    chk <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d, 3'h0, 32'h0);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask

  always @(posedge i_clk) pend <= i_rd | chk;

  // Compare at the falling edge, where outputs have settled
  always @(negedge i_clk) begin
    if (pend && q.size() > 0) begin
      n = q.pop_front();
      case (n.w)
        3'h0: seen = o_rdata;
        3'h1: seen = {31'h0, o_prot_active};
        3'h2: seen = {24'h0, o_mod_active};
        3'h3: seen = {24'h0, o_trip_cmd};
        3'h4: seen = {24'h0, o_mod_blocked};
        default: seen = {30'h0, o_gen_alarm, o_gen_trip};
      endcase
      samples_checked++;
      if (seen !== n.e) begin
        n_mismatch++;
        $display("unexpected %s expected %h seen %h", nm[n.w], n.e, seen);
      end
    end
  end

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Generous bound, the sequence needs a few hundred cycles
  initial begin
    idle(5000);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    idle(2);
    i_nrst <= 1'b1;
    bus(1'b0, 1'b1, `REG_GCTRL, 32'h0, 3'h0, 32'h00000001);
    bus(1'b0, 1'b1, 8'h20, 32'h0, 3'h0, 32'h00000000);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h00000000);
    for (int m = 0; m < 8; m++) wr(8'h20 + 8'(4 * m), 32'h00000001);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h000000ff);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      i_mod_alarm <= seed[7:0];
      i_mod_trip <= seed[15:8];
      bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, {24'h0, seed[15:8]});
      bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h5, {30'h0, |seed[7:0], |seed[15:8]});
    end
    i_mod_alarm <= 8'h00;
    i_mod_trip <= 8'h00;
    i_param_change <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h1, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h0);
    i_param_change <= 1'b0;
    i_meas_ok <= 1'b0;
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h1, 32'h0);
    i_meas_ok <= 1'b1;
    wr(`REG_GCTRL, 32'h00000000);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h0);
    wr(`REG_GCTRL, 32'h00000001);
    wr(`REG_GASSIGN, 32'h00000001);
    i_din <= 8'h01;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h1, 32'h1);
    wr(`REG_GCTRL, 32'h00000003);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h0);
    bus(1'b0, 1'b1, `REG_GSTAT, 32'h0, 3'h0, 32'h0000000a);
    i_din <= 8'h00;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'hff);
    wr(`REG_GASSIGN, 32'h00000801);
    i_din <= 8'h80;
    idle(4);
    bus(1'b0, 1'b1, `REG_GSTAT, 32'h0, 3'h0, 32'h00000012);
    wr(8'h24, 32'h00000003);
    wr(8'h25, 32'h00000200);
    wr(8'h29, 32'h00000200);
    wr(8'h2c, 32'h00000003);
    wr(8'h2d, 32'h00000009);
    i_din <= 8'h02;
    i_mod_trip <= 8'h01;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h4, 32'h0a);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'hf5);
    bus(1'b0, 1'b1, 8'h26, 32'h0, 3'h0, 32'h00000012);
    bus(1'b0, 1'b1, 8'h2a, 32'h0, 3'h0, 32'h00000011);
    wr(8'h20, 32'h00000005);
    wr(8'h34, 32'h00000009);
    wr(8'h35, 32'h00030000);
    i_din <= 8'h04;
    i_mod_trip <= 8'h21;
    i_mod_alarm <= 8'h01;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, 32'h00);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h5, 32'h03);
    bus(1'b0, 1'b1, 8'h36, 32'h0, 3'h0, 32'h00000021);
    bus(1'b0, 1'b1, 8'h35, 32'h0, 3'h0, 32'h00030000);
    i_din <= 8'h00;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, 32'h20);
    wr(`REG_GCTRL, 32'h00000007);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, 32'h00);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h5, 32'h03);
    wr(`REG_GCTRL, 32'h0000000b);
    wr(`REG_GASSIGN, 32'h00020001);
    i_din <= 8'h02;
    idle(4);
    bus(1'b0, 1'b1, `REG_GSTAT, 32'h0, 3'h0, 32'h00000005);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, 32'h00);
    i_din <= 8'h00;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h3, 32'h20);
    i_mod_trip <= 8'h00;
    i_mod_alarm <= 8'h00;
    wr(`REG_GCTRL, 32'h00000013);
    wr(8'h38, 32'h00000011);
    i_freq_in_range <= 1'b0;
    idle(3);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h40);
    bus(1'b0, 1'b1, 8'h22, 32'h0, 3'h0, 32'h000000a0);
    i_freq_in_range <= 1'b1;
    wr(8'h38, 32'h00000061);
    wr(8'h3c, 32'h000000a1);
    wr(8'h30, 32'h000000e1);
    i_rev_interlock <= 1'b1;
    idle(4);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h4, 32'hc0);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 3'h2, 32'h3f);
    bus(1'b0, 1'b1, 8'h3a, 32'h0, 3'h0, 32'h00000042);
    bus(1'b0, 1'b1, 8'h3e, 32'h0, 3'h0, 32'h00000042);
    bus(1'b0, 1'b1, 8'h32, 32'h0, 3'h0, 32'h00000001);
    i_rev_interlock <= 1'b0;
    bus(1'b0, 1'b1, 8'h23, 32'h0, 3'h0, 32'h0);
    wr(`REG_GSTAT, 32'hffffffff);
    bus(1'b0, 1'b1, `REG_GSTAT, 32'h0, 3'h0, 32'h00000001);
    idle(3);
    end_of_test();
  end
endmodule // tb_prot_blocking
